// [adcsp_fifo.sv]
`timescale 1ns/10ps
module adcsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  fifo_bounds_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    count_reg <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

// [adcsp_host_model.sv]
`timescale 1ns/10ps
module adcsp_host_model #(
  parameter int HALF = 5
) (
  input wire logic core_clk_in,
  input wire logic dout_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  task automatic half_clock(input logic bit_val);
    sclk_out <= 1'b0;
    din_out <= bit_val;
    tick(HALF);
  endtask

  // One byte MSB first; serial clock idles high and stands still between frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input logic keep, input logic pause);
    tick(1);
    if (cs_n_out) begin
      cs_n_out <= 1'b0;
      tick(4);
    end
    for (int i = 7; i >= 0; i--) begin
      if (pause && i == 3) begin
        // Deselect mid-byte and toggle the clock; those edges must not count
        cs_n_out <= 1'b1;
        tick(4);
        repeat (3) begin
          half_clock(~din_out);
          sclk_out <= 1'b1;
          tick(HALF);
        end
        cs_n_out <= 1'b0;
        tick(4);
      end
      half_clock(tx[i]);
      rx[i] = dout_in;
      sclk_out <= 1'b1;
      tick(HALF);
    end
    // Holding select low between bytes gives three-wire use
    if (!keep) begin
      cs_n_out <= 1'b1;
      din_out <= ~din_out;
      tick(4);
    end
  endtask
endmodule

// [adcsp_pkg.sv]
package adcsp_pkg;

  // Word widths and buffering
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;

  // Register-select codes carried in the communication register
  localparam logic [2:0] SEL_COMM = 3'h0;
  localparam logic [2:0] SEL_SETUP = 3'h1;
  localparam logic [2:0] SEL_CLOCK = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h3;

  // Communication register fields
  localparam int COMM_WEN_BIT = 7;
  localparam int COMM_RS_HI = 6;
  localparam int COMM_RS_LO = 4;
  localparam int COMM_RW_BIT = 3;
  localparam int COMM_STBY_BIT = 2;
  localparam int COMM_CH_HI = 1;
  localparam int COMM_CH_LO = 0;

  // Clock register fields
  localparam int CLK_DIS_BIT = 4;
  localparam int CLK_DIV_BIT = 3;
  localparam int CLK_FS_HI = 1;
  localparam int CLK_FS_LO = 0;

  // Reset values
  localparam logic [7:0] COMM_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h01;
  localparam logic [7:0] CLOCK_RST = 8'h05;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // Transfer lengths in serial clock edges
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_WORD = 5'h10;

  // Update ticks of data-ready blanking before an update; one tick is one master clock, two with clock divide set
  localparam int PRE_UPDATE_TICKS = 500;

  // Update ticks per output update for each filter rate select; one tick is one master clock, two with clock divide set
  localparam int UPDATE_TICKS_50HZ = 49152;
  localparam int UPDATE_TICKS_60HZ = 40960;
  localparam int UPDATE_TICKS_250HZ = 9830;
  localparam int UPDATE_TICKS_500HZ = 4915;

  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_WR = 3'b010,
    ST_RD = 3'b100
  } adcsp_state_t;

endpackage

// [adcsp_top.sv]
`timescale 1ns/10ps
// Functional notes
// - Serial clock may be continuous or in bursts; transfer state survives idle gaps.
// - With external master clock, clock output pin carries its inverse.
// - Clock-output disable bit stops driving the master clock output pin.
// - Chip select is active low; serial activity only while it is low.
// - Chip select tied low gives three-wire operation on clock, data in, data out.
// - Active-low reset input returns all control and interface logic to power-on state.
// - Data-ready goes low when a new conversion word sits in the data register.
// - Data-ready goes high once a full output word has been read.
// - Unread data: data-ready rises 500 master clocks (1000 with clock divide set) before the next update.
// - Data-ready goes low again once the data register update has completed.
// - Data-ready also flags completion of an on-chip calibration.
// - Output shift register loads from setup, comm, clock or data register by select.
// - Input shift register transfers to setup, clock or comm register by select.
// - Two filter-select bits choose one of four output update rates.
// - After reset the first transfer is a comm write; each access needs one first.
// - Comm register value chooses read or write and the target register.
// - Register-select value zero addresses the communication register.
module adcsp_top
  import adcsp_pkg::*;
#(
  parameter int unsigned UPDATE_TICKS_0 = adcsp_pkg::UPDATE_TICKS_50HZ,
  parameter int unsigned UPDATE_TICKS_1 = adcsp_pkg::UPDATE_TICKS_60HZ,
  parameter int unsigned UPDATE_TICKS_2 = adcsp_pkg::UPDATE_TICKS_250HZ,
  parameter int unsigned UPDATE_TICKS_3 = adcsp_pkg::UPDATE_TICKS_500HZ
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic din_in,
  output logic dout_out,
  output logic dout_oe_out,
  input wire logic mclk_in,
  output logic mclk_out,
  output logic mclk_oe_out,
  input wire logic conv_valid_in,
  input wire logic [adcsp_pkg::WORD_W-1:0] conv_data_in,
  output logic conv_ready_out,
  input wire logic cal_done_in,
  output logic conv_ready_n_out,
  output logic core_reset_out,
  output logic standby_out,
  output logic [1:0] channel_select_out,
  output logic [adcsp_pkg::BYTE_W-1:0] setup_reg_out,
  output logic [adcsp_pkg::BYTE_W-1:0] clock_reg_out
);
  import adcsp_pkg::*;

  // Transfer length of the selected register
  function automatic logic [4:0] reg_len(input logic [2:0] sel);
    reg_len = (sel == SEL_DATA) ? LEN_WORD : LEN_BYTE;
  endfunction

  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_s1, cs_s2;
  logic din_s1, din_s2;
  logic mclk_s1, mclk_s2, mclk_s3;
  logic rstn_s1, rstn_s2;
  logic rst_int;

  adcsp_state_t state_reg;
  logic [4:0] bit_cnt_reg;
  logic [WORD_W-1:0] in_sh_reg;
  logic [WORD_W-1:0] out_sh_reg;
  logic [BYTE_W-1:0] comm_reg;
  logic [BYTE_W-1:0] setup_reg;
  logic [BYTE_W-1:0] clock_reg;
  logic [WORD_W-1:0] data_reg;
  logic dout_reg;
  logic dout_oe_reg;
  logic conversion_ready_n_n_reg;
  logic mclk_out_reg;
  logic mclk_oe_reg;
  logic mdiv_reg;
  logic core_rst_reg;
  logic [15:0] upd_cnt_reg;
  logic [15:0] upd_period;

  logic sclk_rise, sclk_fall, sel_active;
  logic [2:0] target;
  logic [4:0] cur_len;
  logic last_bit;
  logic [WORD_W-1:0] in_word;
  logic [BYTE_W-1:0] cmd_byte;
  logic cmd_done, cmd_accept, wr_done, rd_done, read_data_done;
  logic [WORD_W-1:0] read_value;
  logic mclk_rise, mtick, upd_fire, pre_fire, data_load;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;

  // Pin synchronisers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      sclk_s1 <= sclk_in;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      din_s1 <= din_in;
      din_s2 <= din_s1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
      rstn_s1 <= 1'b1;
      rstn_s2 <= 1'b1;
    end else begin
      mclk_s1 <= mclk_in;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
      rstn_s1 <= reset_n_in;
      rstn_s2 <= rstn_s1;
    end
  end

  assign rst_int = sys_rst_in | ~rstn_s2;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      core_rst_reg <= 1'b1;
    end else begin
      core_rst_reg <= ~rstn_s2;
    end
  end

  // Serial edges only count while selected; idle gaps leave the state alone
  assign sel_active = ~cs_s2;
  assign sclk_rise = sel_active & sclk_s2 & ~sclk_s3;
  assign sclk_fall = sel_active & ~sclk_s2 & sclk_s3;

  assign target = comm_reg[COMM_RS_HI:COMM_RS_LO];
  assign cur_len = (state_reg == ST_CMD) ? LEN_BYTE : reg_len(target);
  assign last_bit = (bit_cnt_reg == cur_len - 5'h01);
  assign in_word = {in_sh_reg[WORD_W-2:0], din_s2};
  assign cmd_byte = in_word[BYTE_W-1:0];
  assign cmd_done = sclk_rise && (state_reg == ST_CMD) && last_bit;
  assign cmd_accept = cmd_done && !cmd_byte[COMM_WEN_BIT];
  assign wr_done = sclk_rise && (state_reg == ST_WR) && last_bit;
  assign rd_done = sclk_rise && (state_reg == ST_RD) && last_bit;
  assign read_data_done = rd_done && (target == SEL_DATA);

  // Read source, left aligned so the MSB leaves first
  always_comb begin
    read_value = '0;
    case (cmd_byte[COMM_RS_HI:COMM_RS_LO])
      SEL_COMM: read_value = {conversion_ready_n_n_reg, cmd_byte[6:0], 8'h00};
      SEL_SETUP: read_value = {setup_reg, 8'h00};
      SEL_CLOCK: read_value = {clock_reg, 8'h00};
      SEL_DATA: read_value = data_reg;
      default: read_value = '0;
    endcase
  end

  // Transfer sequencer
  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      state_reg <= ST_CMD;
      bit_cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
      if (last_bit) begin
        bit_cnt_reg <= 5'h00;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
      case (state_reg)
        ST_CMD: begin
          if (cmd_accept) begin
            if (cmd_byte[COMM_RW_BIT]) begin
              state_reg <= ST_RD;
            end else if (cmd_byte[COMM_RS_HI:COMM_RS_LO] == SEL_COMM) begin
              state_reg <= ST_CMD;
            end else begin
              state_reg <= ST_WR;
            end
          end
        end
        ST_WR: begin
          if (last_bit) begin
            state_reg <= ST_CMD;
          end
        end
        ST_RD: begin
          if (last_bit) begin
            state_reg <= ST_CMD;
          end
        end
        default: state_reg <= ST_CMD;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      in_sh_reg <= '0;
    end else if (sclk_rise && (state_reg != ST_RD)) begin
      in_sh_reg <= in_word;
    end
  end

  // Register writes from the input shift register
  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      comm_reg <= COMM_RST;
    end else if (cmd_accept) begin
      comm_reg <= {1'b0, cmd_byte[6:0]};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      setup_reg <= SETUP_RST;
    end else if (wr_done && (target == SEL_SETUP)) begin
      setup_reg <= in_word[BYTE_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      clock_reg <= CLOCK_RST;
    end else if (wr_done && (target == SEL_CLOCK)) begin
      clock_reg <= in_word[BYTE_W-1:0];
    end
  end

  // Output shift register; new bit presented on each falling serial edge
  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      out_sh_reg <= '0;
      dout_reg <= 1'b0;
    end else if (cmd_accept && cmd_byte[COMM_RW_BIT]) begin
      out_sh_reg <= read_value;
    end else if (sclk_fall && (state_reg == ST_RD)) begin
      dout_reg <= out_sh_reg[WORD_W-1];
      out_sh_reg <= {out_sh_reg[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      dout_oe_reg <= 1'b0;
    end else begin
      dout_oe_reg <= sel_active;
    end
  end

  // Master clock: inverted copy out, and tick for update timing
  assign mclk_rise = mclk_s2 & ~mclk_s3;
  assign mtick = mclk_rise & (~clock_reg[CLK_DIV_BIT] | mdiv_reg);

  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      mdiv_reg <= 1'b0;
    end else if (mclk_rise) begin
      mdiv_reg <= ~mdiv_reg;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      mclk_out_reg <= 1'b0;
      mclk_oe_reg <= 1'b0;
    end else if (clock_reg[CLK_DIS_BIT]) begin
      mclk_out_reg <= 1'b0;
      mclk_oe_reg <= 1'b0;
    end else begin
      mclk_out_reg <= ~mclk_s2;
      mclk_oe_reg <= 1'b1;
    end
  end

  // Update pacing by filter rate select
  always_comb begin
    upd_period = 16'(UPDATE_TICKS_0);
    case (clock_reg[CLK_FS_HI:CLK_FS_LO])
      2'h0: upd_period = 16'(UPDATE_TICKS_0);
      2'h1: upd_period = 16'(UPDATE_TICKS_1);
      2'h2: upd_period = 16'(UPDATE_TICKS_2);
      2'h3: upd_period = 16'(UPDATE_TICKS_3);
      default: upd_period = 16'(UPDATE_TICKS_0);
    endcase
  end

  assign upd_fire = mtick && (upd_cnt_reg >= upd_period - 16'h0001);
  assign pre_fire = mtick && (upd_cnt_reg == upd_period - 16'h0001 - 16'(PRE_UPDATE_TICKS));
  assign data_load = upd_fire && fifo_valid;

  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      upd_cnt_reg <= 16'h0000;
    end else if (upd_fire) begin
      upd_cnt_reg <= 16'h0000;
    end else if (mtick) begin
      upd_cnt_reg <= upd_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      data_reg <= DATA_RST;
    end else if (data_load) begin
      data_reg <= fifo_data;
    end
  end

  // Data-ready: a new word or a finished calibration wins over read completion
  always_ff @(posedge core_clk_in) begin
    if (rst_int) begin
      conversion_ready_n_n_reg <= 1'b1;
    end else if (data_load || cal_done_in) begin
      conversion_ready_n_n_reg <= 1'b0;
    end else if (read_data_done) begin
      conversion_ready_n_n_reg <= 1'b1;
    end else if (pre_fire && !conversion_ready_n_n_reg && fifo_valid) begin
      conversion_ready_n_n_reg <= 1'b1;
    end
  end

  adcsp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .sys_rst_in(rst_int),
    .in_valid_in(conv_valid_in),
    .in_data_in(conv_data_in),
    .in_ready_out(conv_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(data_load)
  );

  assign dout_out = dout_reg;
  assign dout_oe_out = dout_oe_reg;
  assign mclk_out = mclk_out_reg;
  assign mclk_oe_out = mclk_oe_reg;
  assign conv_ready_n_out = conversion_ready_n_n_reg;
  assign core_reset_out = core_rst_reg;
  assign standby_out = comm_reg[COMM_STBY_BIT];
  assign channel_select_out = comm_reg[COMM_CH_HI:COMM_CH_LO];
  assign setup_reg_out = setup_reg;
  assign clock_reg_out = clock_reg;

  reset_state_a: assert property (@(posedge core_clk_in)
    rst_int |=> (state_reg == ST_CMD) && conv_ready_n_out && (comm_reg == COMM_RST))
    else $error("reset did not restore power-on state");
  cs_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_int)
    cs_s2 |=> !dout_oe_out && $stable(state_reg))
    else $error("serial activity while deselected");
  clk_disable_a: assert property (@(posedge core_clk_in) disable iff (rst_int)
    clock_reg[CLK_DIS_BIT] |=> !mclk_oe_out && !mclk_out)
    else $error("clock output driven while disabled");
  clk_invert_a: assert property (@(posedge core_clk_in) disable iff (rst_int)
    !clock_reg[CLK_DIS_BIT] ##1 !clock_reg[CLK_DIS_BIT] |-> mclk_out == !$past(mclk_s2))
    else $error("clock output not inverse of input");
  new_word_a: assert property (@(posedge core_clk_in) disable iff (rst_int)
    data_load |=> !conv_ready_n_out && (data_reg == $past(fifo_data)))
    else $error("data-ready not low after update");
  read_done_a: assert property (@(posedge core_clk_in) disable iff (rst_int)
    read_data_done && !data_load && !cal_done_in |=> conv_ready_n_out && (state_reg == ST_CMD))
    else $error("data-ready not high after full read");
  pre_update_a: assert property (@(posedge core_clk_in) disable iff (rst_int)
    pre_fire && !conv_ready_n_out && fifo_valid && !cal_done_in && !read_data_done |=> conv_ready_n_out)
    else $error("no blanking before update");
  cal_done_a: assert property (@(posedge core_clk_in) disable iff (rst_int)
    cal_done_in |=> !conv_ready_n_out)
    else $error("calibration end not flagged");
  cmd_route_a: assert property (@(posedge core_clk_in) disable iff (rst_int)
    cmd_accept && cmd_byte[COMM_RW_BIT] |=> (state_reg == ST_RD) && (bit_cnt_reg == 5'h00))
    else $error("read command not routed");
  read_len_a: assert property (@(posedge core_clk_in) disable iff (rst_int)
    rd_done |-> bit_cnt_reg == ((target == SEL_DATA) ? LEN_WORD : LEN_BYTE) - 5'h01)
    else $error("read length wrong");

  data_read_c: cover property (@(posedge core_clk_in) disable iff (rst_int) read_data_done);
  clock_write_c: cover property (@(posedge core_clk_in) disable iff (rst_int)
    wr_done && (target == SEL_CLOCK));
  pre_blank_c: cover property (@(posedge core_clk_in) disable iff (rst_int)
    pre_fire && !conv_ready_n_out && fifo_valid);
endmodule

// [adcsp_top_tb.sv]
`timescale 1ns/10ps
module adcsp_top_tb;
  import adcsp_pkg::*;
  localparam int MC_HALF = 4;
  localparam int MC_PER = 2 * MC_HALF;
  localparam int TT [4] = '{560, 580, 600, 620};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_n = 1'b1;
  logic sclk, cs_n, din, dout, dout_oe;
  logic mclk = 1'b0;
  logic mclk_out, mclk_oe;
  logic conv_valid = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  logic conv_ready;
  logic cal_done = 1'b0;
  logic conversion_ready_n_n, core_reset, standby;
  logic [1:0] chan;
  logic [7:0] setup_reg, clock_reg;
  logic [15:0] lfsr = 16'h0041;
  logic push_en = 1'b0;
  logic conversion_ready_n_q = 1'b1;
  logic [15:0] pushed [$];
  int mcnt = 0;
  int cyc = 0;
  int upd_cnt = 0;
  int fall_cyc = 0;
  int rise_cyc = 0;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #12.5 clk = ~clk;

  adcsp_top #(.UPDATE_TICKS_0(TT[0]), .UPDATE_TICKS_1(TT[1]), .UPDATE_TICKS_2(TT[2]), .UPDATE_TICKS_3(TT[3])) dut (
    .core_clk_in(clk), .sys_rst_in(sys_rst), .reset_n_in(reset_n), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe), .mclk_in(mclk), .mclk_out(mclk_out),
    .mclk_oe_out(mclk_oe), .conv_valid_in(conv_valid), .conv_data_in(conv_data), .conv_ready_out(conv_ready),
    .cal_done_in(cal_done), .conv_ready_n_out(conversion_ready_n_n), .core_reset_out(core_reset), .standby_out(standby),
    .channel_select_out(chan), .setup_reg_out(setup_reg), .clock_reg_out(clock_reg)
  );

  // Undriven data line shows the inverse of the last bit, so a late enable is caught
  adcsp_host_model host (.core_clk_in(clk), .dout_in(dout_oe ? dout : ~dout), .sclk_out(sclk), .cs_n_out(cs_n),
    .din_out(din));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Master clock at 5 MHz, the top of the supported range
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mcnt <= (mcnt == MC_HALF - 1) ? 0 : mcnt + 1;
    if (mcnt == MC_HALF - 1) mclk <= ~mclk;
    if (conv_valid && conv_ready) pushed.push_back(conv_data);
    if (push_en && (!conv_valid || conv_ready)) begin
      conv_valid <= 1'b1;
      conv_data <= lfsr;
      lfsr <= lfsr_next(lfsr);
    end
    if (!sys_rst) begin
      conversion_ready_n_q <= conversion_ready_n_n;
      if (conversion_ready_n_q && !conversion_ready_n_n) begin
        upd_cnt <= upd_cnt + 1;
        fall_cyc <= cyc;
      end
      if (!conversion_ready_n_q && conversion_ready_n_n) rise_cyc <= cyc;
    end
  end

  task automatic results;
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  task automatic settle;
    repeat (3) @(negedge clk);
  endtask

  task automatic wait_upd;
    int n0;
    n0 = upd_cnt;
    for (int i = 0; i < 12000 && upd_cnt == n0; i++) @(posedge clk);
    if (upd_cnt == n0) begin
      chk(1'b0, "no output update");
      results();
    end
  endtask

  task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] val, input logic keep);
    logic [7:0] rx;
    host.xfer(cmd, rx, 1'b1, 1'b0);
    host.xfer(val, rx, keep, 1'b0);
    settle();
  endtask

  task automatic rd_reg(input logic [7:0] cmd, output logic [7:0] val, input logic keep, input logic pause);
    logic [7:0] rx;
    host.xfer(cmd, rx, 1'b1, 1'b0);
    host.xfer(8'h00, val, keep, pause);
  endtask

  // Read only right after data-ready falls, never while it is high
  task automatic rd_word_chk;
    logic [7:0] rx;
    logic [15:0] w;
    int k;
    k = upd_cnt;
    host.xfer(8'h38, rx, 1'b1, 1'b0);
    host.xfer(8'h00, w[15:8], 1'b1, 1'b0);
    host.xfer(8'h00, w[7:0], 1'b0, 1'b0);
    chk(w === pushed[k-1], "data word");
    settle();
    chk(conversion_ready_n_n === 1'b1, "ready not high after read");
  endtask

  initial begin
    logic [7:0] r, rx;
    int t0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk(setup_reg === SETUP_RST && clock_reg === CLOCK_RST && conversion_ready_n_n === 1'b1, "reset values");
    @(negedge clk);
    chk(mclk_oe === 1'b1, "clock output off");
    @(posedge clk);
    push_en <= 1'b1;
    for (int i = 0; i < 40 && conv_ready !== 1'b0; i++) @(negedge clk);
    chk(pushed.size() == FIFO_DEPTH, "fifo depth");
    repeat (30) begin
      @(negedge clk);
      if (mcnt == MC_HALF - 1) chk(mclk_out === ~mclk, "clock output not inverse");
    end
    r = lfsr[7:0];
    wr_reg(8'h10, r, 1'b1);
    chk(setup_reg === r, "setup write");
    rd_reg(8'h18, rx, 1'b1, 1'b1);
    chk(rx === r, "setup read with pause");
    wr_reg(8'h20, 8'h06, 1'b0);
    chk(clock_reg === 8'h06, "clock write");
    rd_reg(8'h28, rx, 1'b0, 1'b0);
    chk(rx === 8'h06, "clock read");
    host.xfer(8'h90, rx, 1'b1, 1'b0);
    wr_reg(8'h20, 8'h05, 1'b0);
    chk(setup_reg === r && clock_reg === 8'h05, "bad command taken");
    host.xfer(8'h05, rx, 1'b0, 1'b0);
    settle();
    chk(standby === 1'b1 && chan === 2'h1, "comm write");
    rd_reg(8'h08, rx, 1'b0, 1'b0);
    chk(rx === 8'h88, "comm read");
    rd_reg(8'h48, rx, 1'b0, 1'b0);
    chk(rx === 8'h00, "unused register read");
    settle();
    chk(dout_oe === 1'b0, "data out driven while deselected");
    repeat (3) begin
      wait_upd();
      rd_word_chk();
    end
    wait_upd();
    wait_upd();
    t0 = fall_cyc - rise_cyc - PRE_UPDATE_TICKS * MC_PER;
    chk(t0 >= -5 && t0 <= 5, "blank length");
    rd_word_chk();
    for (int j = 0; j < 4; j++) begin
      wr_reg(8'h20, 8'h04 | 8'(j), 1'b0);
      wait_upd();
      t0 = fall_cyc;
      wait_upd();
      t0 = fall_cyc - t0 - TT[j] * MC_PER;
      chk(t0 >= -5 && t0 <= 5, "update interval");
    end
    wr_reg(8'h20, 8'h1d, 1'b0);
    chk(mclk_oe === 1'b0 && mclk_out === 1'b0, "clock output not stopped");
    wait_upd();
    t0 = fall_cyc;
    wait_upd();
    t0 = fall_cyc - t0 - 2 * TT[1] * MC_PER;
    chk(t0 >= -5 && t0 <= 5, "divided update interval");
    rd_word_chk();
    @(posedge clk);
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    repeat (2) @(negedge clk);
    chk(conversion_ready_n_n === 1'b0, "calibration end not flagged");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk(core_reset === 1'b1 && conversion_ready_n_n === 1'b1, "pin reset");
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(negedge clk);
    chk(clock_reg === CLOCK_RST && setup_reg === SETUP_RST && mclk_oe === 1'b1, "pin reset values");
    results();
  end
endmodule
